// ### verilog/psc_pkg.sv
// Package for the pin state controller: conditions, pin functions, codes.
// Assumes a single clock domain; no software-visible registers.
package psc_pkg;

    // ----------------------------------------
    // Device condition, priority order
    // ----------------------------------------
    typedef enum logic [2:0] {
        PSC_COND_UNSTABLE,
        PSC_COND_EXT_RESET,
        PSC_COND_INT_RESET,
        PSC_COND_RUN,
        PSC_COND_STBY_KEEP,
        PSC_COND_STBY_FLOAT
    } psc_cond_t;

    // ----------------------------------------
    // Pin function selection
    // ----------------------------------------
    typedef enum logic [2:0] {
        PSC_FN_GPIO,
        PSC_FN_MAIN_OSC_IN,
        PSC_FN_MAIN_OSC_OUT,
        PSC_FN_SUB_OSC_IN,
        PSC_FN_SUB_OSC_OUT,
        PSC_FN_EXT_INT,
        PSC_FN_DEBUG,
        PSC_FN_ANALOG
    } psc_fn_t;

    localparam int unsigned PSC_FN_W      = 3;
    localparam logic        PSC_LEVEL_KEEP  = 1'b0;
    localparam logic        PSC_LEVEL_FLOAT = 1'b1;
    localparam logic        PSC_IN_FORCED   = 1'b0;
    localparam logic        PSC_OE_RESET    = 1'b0;
    localparam logic        PSC_OUT_RESET   = 1'b0;
    localparam logic        PSC_LEVEL_BIT_RESET = 1'b0;
    localparam int unsigned PSC_NUM_PINS    = 8;

endpackage

// ### verilog/psc_cond_decode.sv
// Condition decoder: turns power, reset and mode levels into one condition.
// Assumes all inputs are synchronous to the clock.
module psc_cond_decode (
    // Status levels
    input  wire logic              power_stable,
    input  wire logic              ext_reset_n,
    input  wire logic              int_reset,
    input  wire logic              standby,
    input  wire logic              standby_pin_level,
    // Decoded condition
    output psc_pkg::psc_cond_t     cond
);
    // ----------------------------------------
    // Priority select
    // ----------------------------------------
    always_comb begin
        if (!power_stable) begin
            cond = psc_pkg::PSC_COND_UNSTABLE;
        end else if (!ext_reset_n) begin
            cond = psc_pkg::PSC_COND_EXT_RESET;
        end else if (int_reset) begin
            cond = psc_pkg::PSC_COND_INT_RESET;
        end else if (!standby) begin
            cond = psc_pkg::PSC_COND_RUN;
        end else if (standby_pin_level == psc_pkg::PSC_LEVEL_FLOAT) begin
            cond = psc_pkg::PSC_COND_STBY_FLOAT;
        end else begin
            cond = psc_pkg::PSC_COND_STBY_KEEP;
        end
    end
endmodule

// ### verilog/psc_pin_cell.sv
// One pin cell: applies the condition table to a single pin.
// Assumes the function code and peripheral drive come from the pin mux.
module psc_pin_cell (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Condition and selection
    input  psc_pkg::psc_cond_t     cond,
    input  wire logic [2:0]        fn,
    input  wire logic              periph_active,
    input  wire logic              osc_running,
    // Functional side
    input  wire logic              func_out,
    input  wire logic              func_oe,
    output logic                   func_in,
    // Pad side
    input  wire logic              pad_in,
    output logic                   pad_out,
    output logic                   pad_oe,
    output logic                   pad_pull_up,
    output logic                   analog_en
);
    typedef struct packed {
        logic out;
        logic oe;
    } psc_cell_t;

    psc_cell_t st_reg;
    psc_cell_t st_next;
    psc_pkg::psc_fn_t f;
    logic keep;
    logic rst_cond;
    logic forced;

    assign f        = psc_pkg::psc_fn_t'(fn);
    assign rst_cond = (cond == psc_pkg::PSC_COND_EXT_RESET) ||
                      (cond == psc_pkg::PSC_COND_INT_RESET);

    // ----------------------------------------
    // Pin table
    // ----------------------------------------
    always_comb begin
        keep        = 1'b0;
        forced      = 1'b0;
        pad_pull_up = 1'b0;
        analog_en   = 1'b0;
        unique case (f)
            psc_pkg::PSC_FN_MAIN_OSC_IN, psc_pkg::PSC_FN_SUB_OSC_IN: begin
                keep = 1'b0;
            end
            psc_pkg::PSC_FN_MAIN_OSC_OUT: begin
                forced = (cond != psc_pkg::PSC_COND_UNSTABLE) &&
                         (rst_cond || !osc_running);
                keep   = !forced && !rst_cond && (cond != psc_pkg::PSC_COND_UNSTABLE);
            end
            psc_pkg::PSC_FN_SUB_OSC_OUT: begin
                forced = rst_cond || ((cond == psc_pkg::PSC_COND_STBY_KEEP ||
                         cond == psc_pkg::PSC_COND_STBY_FLOAT) && !osc_running);
                keep   = !forced && (cond != psc_pkg::PSC_COND_UNSTABLE);
            end
            psc_pkg::PSC_FN_EXT_INT: begin
                keep = (cond >= psc_pkg::PSC_COND_RUN);
            end
            psc_pkg::PSC_FN_DEBUG: begin
                pad_pull_up = rst_cond;
                keep        = (cond >= psc_pkg::PSC_COND_RUN);
            end
            psc_pkg::PSC_FN_ANALOG: begin
                analog_en = (cond != psc_pkg::PSC_COND_UNSTABLE);
                forced    = analog_en;
            end
            default: begin
                forced = (cond == psc_pkg::PSC_COND_STBY_FLOAT) ||
                         (!periph_active && (cond < psc_pkg::PSC_COND_RUN));
                keep   = (cond == psc_pkg::PSC_COND_RUN) ||
                         (cond == psc_pkg::PSC_COND_STBY_KEEP);
            end
        endcase
    end

    // ----------------------------------------
    // Drive state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        if (keep) begin
            if (periph_active || cond == psc_pkg::PSC_COND_RUN) begin
                st_next.out = func_out;
                st_next.oe  = func_oe;
            end
        end else begin
            st_next.out = psc_pkg::PSC_OUT_RESET;
            st_next.oe  = psc_pkg::PSC_OE_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{out: psc_pkg::PSC_OUT_RESET, oe: psc_pkg::PSC_OE_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pad_out = st_reg.out;
    assign pad_oe  = st_reg.oe;
    assign func_in = forced ? psc_pkg::PSC_IN_FORCED : pad_in;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_forced_low: assert property (@(posedge clk) disable iff (!rst_n)
        (analog_en || (f == psc_pkg::PSC_FN_GPIO && cond == psc_pkg::PSC_COND_STBY_FLOAT))
        |-> func_in == psc_pkg::PSC_IN_FORCED) else $error("Forced input not low");
    a_reset_float: assert property (@(posedge clk) disable iff (!rst_n)
        !keep |=> !pad_oe) else $error("Pad driven outside keep");
    a_analog_dig_off: assert property (@(posedge clk) disable iff (!rst_n)
        analog_en |=> !pad_oe) else $error("Analog pin driven");
endmodule

// ### verilog/psc_top.sv
// Pin state controller top: decodes device condition and drives each pin.
// Assumes power, reset and mode levels come from the clock/reset logic.
//
// Notes on behaviour
// - Pin state from six device conditions
// - Reset states float every pin; pull-up, analog and input follow pin function
// - Kept state: peripheral drives, port holds
// - GPIO keeps state, floats at level one
// - Main clock input pin always enabled
// - Main oscillator output floats in reset, stop
// - Sub clock input pin always enabled
// - Sub oscillator output floats in reset, and in standby when oscillation stops
// - Interrupt pins keep state in run and standby modes
// - Debug pins float, pull-up in reset
// - Analog pins: digital off, analog on once power is stable
// - Other resources float, input forced low
// - Level bit selects standby column
// - Float is driver off; forced is low
module psc_top #(
    parameter int unsigned NUM_PINS = psc_pkg::PSC_NUM_PINS
) (
    // Clock and reset
    input  wire logic                      MCLK,
    input  wire logic                      RESET_N,
    // Device status
    input  wire logic                      POWER_STABLE,
    input  wire logic                      EXTERNAL_RESET_PIN_N,
    input  wire logic                      INTERNAL_RESET,
    input  wire logic                      STANDBY_MODE,
    input  wire logic                      STANDBY_PIN_LEVEL,
    input  wire logic                      MAIN_OSC_RUNNING,
    input  wire logic                      SUB_OSC_RUNNING,
    // Pin configuration
    input  wire logic [3*NUM_PINS-1:0]     PIN_FUNCTION,
    input  wire logic [NUM_PINS-1:0]       PERIPH_ACTIVE,
    // Functional side
    input  wire logic [NUM_PINS-1:0]       FUNC_OUT,
    input  wire logic [NUM_PINS-1:0]       FUNC_OE,
    output logic      [NUM_PINS-1:0]       FUNC_IN,
    // Pads
    input  wire logic [NUM_PINS-1:0]       PAD_IN,
    output logic      [NUM_PINS-1:0]       PAD_OUT,
    output logic      [NUM_PINS-1:0]       PAD_OE,
    output logic      [NUM_PINS-1:0]       PAD_PULL_UP,
    output logic      [NUM_PINS-1:0]       ANALOG_EN,
    // Status
    output logic      [2:0]                PIN_CONDITION
);
    typedef struct packed {
        logic [2:0] cond;
    } psc_top_t;

    psc_top_t           st_reg;
    psc_top_t           st_next;
    psc_pkg::psc_cond_t cond_now;

    // ----------------------------------------
    // Condition
    // ----------------------------------------
    // six-way condition decode
    psc_cond_decode u_dec (
        .power_stable      (POWER_STABLE),
        .ext_reset_n       (EXTERNAL_RESET_PIN_N),
        .int_reset         (INTERNAL_RESET),
        .standby           (STANDBY_MODE),
        .standby_pin_level (STANDBY_PIN_LEVEL),
        .cond              (cond_now)
    );

    always_comb begin
        st_next      = st_reg;
        st_next.cond = cond_now;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '{cond: psc_pkg::PSC_COND_UNSTABLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign PIN_CONDITION = st_reg.cond;

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic osc;
        assign osc = (PIN_FUNCTION[3*i +: 3] == 3'h2) ? MAIN_OSC_RUNNING : SUB_OSC_RUNNING;
        psc_pin_cell u_cell (
            .clk           (MCLK),
            .rst_n         (RESET_N),
            .cond          (cond_now),
            .fn            (PIN_FUNCTION[3*i +: 3]),
            .periph_active (PERIPH_ACTIVE[i]),
            .osc_running   (osc),
            .func_out      (FUNC_OUT[i]),
            .func_oe       (FUNC_OE[i]),
            .func_in       (FUNC_IN[i]),
            .pad_in        (PAD_IN[i]),
            .pad_out       (PAD_OUT[i]),
            .pad_oe        (PAD_OE[i]),
            .pad_pull_up   (PAD_PULL_UP[i]),
            .analog_en     (ANALOG_EN[i])
        );
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_unstable_first: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !POWER_STABLE |=> st_reg.cond == 3'h0) else $error("Unstable not first");
    a_ext_reset: assert property (@(posedge MCLK) disable iff (!RESET_N)
        POWER_STABLE && !EXTERNAL_RESET_PIN_N |=> st_reg.cond == 3'h1)
        else $error("External reset not decoded");
    a_level_column: assert property (@(posedge MCLK) disable iff (!RESET_N)
        POWER_STABLE && EXTERNAL_RESET_PIN_N && !INTERNAL_RESET && STANDBY_MODE
        && STANDBY_PIN_LEVEL |=> st_reg.cond == 3'h5) else $error("Level bit ignored");
    a_unstable_float: assert property (@(posedge MCLK) disable iff (!RESET_N)
        !POWER_STABLE [*2] |-> PAD_OE == '0) else $error("Pad driven while unstable");
    a_run_passthru: assert property (@(posedge MCLK) disable iff (!RESET_N)
        POWER_STABLE && EXTERNAL_RESET_PIN_N && !INTERNAL_RESET && !STANDBY_MODE
        && PIN_FUNCTION[2:0] == 3'h0 |=> PAD_OE[0] == $past(FUNC_OE[0]))
        else $error("Run pin not following port");
    c_standby_float: cover property (@(posedge MCLK) st_reg.cond == 3'h5);
    c_standby_keep: cover property (@(posedge MCLK) st_reg.cond == 3'h4);
    c_int_reset: cover property (@(posedge MCLK) st_reg.cond == 3'h2);
endmodule

// ### dv/psc_board_model.sv
// Board circuitry model: resolves the level on each pad seen by the device.
// Assumes pad enables are high while the device drives a pin.
module psc_board_model (
    // Clock
    input  wire logic       clk,
    // Device pads
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pull_up,
    // Board side
    output logic      [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] noise_reg = 8'h5A;

    // Undriven pads without pull-up wander every cycle, away from the sampling edge
    always @(negedge clk) begin
        noise_reg <= ~noise_reg;
    end

    always_comb begin
        pad_in = (pad_oe & pad_out) | (~pad_oe & (pad_pull_up | noise_reg));
    end
endmodule

// ### dv/test_pin_state_controller.sv
// Self-checking bench for the pin state controller top.
// Assumes the design package and the board model are compiled first.
module test_pin_state_controller;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    typedef struct {logic [2:0] c; logic [7:0] oe, oem, out, pu, pum, an, anm, fz, ff;} psc_exp_t;
    logic        mclk = 1'b0;
    logic        reset_n, pwr_ok, ext_n, int_rst, stby, stby_level, main_run, sub_run;
    logic [23:0] pin_fn;
    logic [7:0]  periph, f_out, f_oe, f_in, pad_in, pad_out, pad_oe, pull, ana;
    logic [7:0]  run_oe, run_out;
    logic [2:0]  cond;
    logic [31:0] r;
    psc_exp_t    q[$];
    psc_exp_t    e;
    int          failures = 0;
    int          comparisons = 0;
    int          seed = 88;

    initial begin
        forever #5 mclk = ~mclk;
    end

    psc_top #(.NUM_PINS(8)) i_psc_top (
        .MCLK(mclk), .RESET_N(reset_n), .POWER_STABLE(pwr_ok),
        .EXTERNAL_RESET_PIN_N(ext_n), .INTERNAL_RESET(int_rst), .STANDBY_MODE(stby),
        .STANDBY_PIN_LEVEL(stby_level), .MAIN_OSC_RUNNING(main_run),
        .SUB_OSC_RUNNING(sub_run), .PIN_FUNCTION(pin_fn), .PERIPH_ACTIVE(periph),
        .FUNC_OUT(f_out), .FUNC_OE(f_oe), .FUNC_IN(f_in), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULL_UP(pull), .ANALOG_EN(ana),
        .PIN_CONDITION(cond));

    psc_board_model i_psc_board_model (
        .clk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pull), .pad_in(pad_in));

    // ----------------------------------------
    // Expected pin table
    // ----------------------------------------
    function automatic psc_exp_t build(input logic [2:0] c);
        psc_exp_t   x;
        logic [2:0] f;
        logic       kp;
        logic       rst;
        x = '{c: c, default: '0};
        rst = (c == 3'h1) || (c == 3'h2);
        for (int i = 0; i < 8; i++) begin
            f = pin_fn[3*i +: 3];
            kp = 1'b0;
            x.oem[i] = 1'b1;
            x.pum[i] = 1'b1;
            x.anm[i] = 1'b1;
            x.an[i] = (f == 3'h7) && (c != 3'h0);
            case (f)
                3'h1, 3'h3: x.ff[i] = 1'b1;
                3'h2: begin
                    x.ff[i] = (c == 3'h0);
                    x.fz[i] = (c != 3'h0) && (rst || !main_run);
                    kp = (c >= 3'h3) && main_run;
                end
                3'h4: begin
                    x.fz[i] = rst || ((c > 3'h3) && !sub_run);
                    kp = (c == 3'h3) || ((c > 3'h3) && sub_run);
                end
                3'h5: kp = (c >= 3'h3);
                3'h6: begin
                    x.pu[i] = rst;
                    x.ff[i] = rst;
                    kp = (c >= 3'h3);
                    x.pum[i] = (c < 3'h3);
                end
                3'h7: x.fz[i] = (c != 3'h0);
                default: begin
                    x.fz[i] = (c == 3'h5);
                    kp = (c == 3'h3) || (c == 3'h4);
                end
            endcase
            if (kp) begin
                x.ff[i] = 1'b1;
                x.oe[i] = (c == 3'h3 || periph[i]) ? f_oe[i] : run_oe[i];
                x.out[i] = (c == 3'h3 || periph[i]) ? f_out[i] : run_out[i];
            end
        end
        return x;
    endfunction

    function automatic logic [2:0] cond_of();
        return !pwr_ok ? 3'h0 : !ext_n ? 3'h1 : int_rst ? 3'h2 :
               !stby ? 3'h3 : stby_level ? 3'h5 : 3'h4;
    endfunction

    task automatic step();
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        q.push_back(build(cond_of()));
        @(negedge mclk);
    endtask

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        comparisons++;
        if (((got ^ exp) & m) !== 8'h00) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge mclk) begin
        if (q.size() > 0) begin
            e = q.pop_front();
            cmp({5'h00, cond}, {5'h00, e.c}, 8'h07);
            cmp(pad_oe, e.oe, e.oem);
            cmp(pad_out, e.out, e.oe & e.oem);
            cmp(pull, e.pu, e.pum);
            cmp(ana, e.an, e.anm);
            cmp(f_in, 8'h00, e.fz);
            cmp(f_in, pad_in, e.ff);
        end
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        {reset_n, pwr_ok, ext_n, int_rst, stby, stby_level, main_run, sub_run} = 8'h63;
        {pin_fn, periph, f_out, f_oe, run_oe, run_out} = '0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        for (int it = 0; it < 96; it++) begin
            for (int i = 0; i < 8; i++) begin
                pin_fn[3*i +: 3] = 3'(i + it);
            end
            {pwr_ok, ext_n, int_rst, stby, stby_level, main_run, sub_run} = 7'h63;
            {periph, f_oe, f_out} = 24'($random(seed));
            step();
            run_oe = f_oe;
            run_out = f_out;
            r = $random(seed);
            pwr_ok = r[0] | r[1];
            ext_n = r[2] | r[3];
            int_rst = r[4] & r[5];
            stby = r[6] | r[7];
            stby_level = r[8];
            main_run = r[9];
            sub_run = r[10];
            {periph, f_oe, f_out} = 24'($random(seed));
            step();
        end
        repeat (3) @(posedge mclk);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        report_and_stop();
    end
endmodule
